// ==== include/ras_pkg.sv ====
// package for the return-address stack control block
package ras_pkg;
   // register addresses on the plain register port
   localparam logic [2:0] ADDR_STACK_PTR = 3'h0;
   localparam logic [2:0] ADDR_TOP_LOW  = 3'h1;
   localparam logic [2:0] ADDR_TOP_HIGH = 3'h2;
   localparam logic [2:0] ADDR_TOP_UPP  = 3'h3;
   localparam logic [2:0] ADDR_CONFIG   = 3'h4;
   localparam logic [2:0] ADDR_IRQ_STAT = 3'h5;
   localparam logic [2:0] ADDR_IRQ_CLR  = 3'h6;
   localparam logic [2:0] ADDR_IRQ_EN   = 3'h7;
   // stack pointer register field positions
   localparam int FULL_BIT  = 7;
   localparam int UNF_BIT   = 6;
   localparam int LEVEL_MSB = 4;
   // interrupt status bit positions
   localparam int IRQ_FULL  = 0;
   localparam int IRQ_UNF   = 1;
   localparam int IRQ_W     = 2;
   // reset values
   localparam logic [4:0] LEVEL_RST  = 5'h0_0;
   localparam logic [7:0] CONFIG_RST = 8'h0_0;
   // pulse length of the stack-condition device reset request
   localparam int RST_PULSE_CYC = 1;

   typedef struct packed {
      logic push;
      logic pop;
      logic call;
      logic ret;
   } ras_op_t;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ras_bus_t;
endpackage

// ==== logic/ras_ctrl.sv ====
// return-address stack with pointer, flags, top-entry access and interrupts
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - software can read and write the top stack entry over the register port.
// - a push raises the pointer by one and stores the program counter in the new top.
// - after a push software may overwrite the upper, high and low bytes of the top entry.
// - a pop lowers the pointer by one so the earlier entry becomes the top.
// - one configuration bit selects whether a full or underflow resets the device.
// - with that bit clear a full or underflow sets its flag and its interrupt status bit but requests no device reset.
// - with that bit set a full or underflow sets its flag and requests a device reset in the same cycle.
// - the flags clear only by a software write or power-on reset, never by other resets.
// - the full flag sits in bit 7 of the pointer register and is set on full or overflow.
// - the underflow flag sits in bit 6 and is set on underflow.
module ras_ctrl #(
   parameter int PC_W  = 21,
   parameter int DEPTH = 31
) (
   // clock and power-on reset
   input  wire logic              I_CLK,
   input  wire logic              I_RSTN,
   // instruction sequencer
   input  wire ras_pkg::ras_op_t  I_OP,
   input  wire logic [PC_W-1:0]   I_PC,
   output logic [PC_W-1:0]        O_TOP,
   // register port
   input  wire ras_pkg::ras_bus_t I_BUS,
   output logic [7:0]             O_RDATA,
   // device reset request and interrupt
   output logic                   O_DEV_RESET,
   output logic                   O_IRQ
);
   logic [PC_W-1:0] stack [1:DEPTH];
   logic [4:0]      level;
   logic            full_flag;
   logic            unf_flag;
   logic            ovr_rst_en;
   logic [ras_pkg::IRQ_W-1:0] irq_stat;
   logic [ras_pkg::IRQ_W-1:0] irq_en;
   logic [PC_W-1:0] top_val;
   logic            do_inc;
   logic            do_dec;
   logic            ev_full;
   logic            ev_unf;
   logic            wr_ptr;
   logic            wr_top;
   logic [23:0]     top_ext;
   logic [23:0]     next_top_ext;
   logic [4:0]      next_level;

   assign do_inc  = I_OP.push | I_OP.call;
   assign do_dec  = I_OP.pop | I_OP.ret;
   assign wr_ptr  = I_BUS.wr && (I_BUS.addr == ras_pkg::ADDR_STACK_PTR);
   assign wr_top  = I_BUS.wr && (I_BUS.addr == ras_pkg::ADDR_TOP_LOW ||
                    I_BUS.addr == ras_pkg::ADDR_TOP_HIGH ||
                    I_BUS.addr == ras_pkg::ADDR_TOP_UPP);
   // full when the last slot is filled or a push finds no room
   assign ev_full = do_inc && (level >= 5'(DEPTH - 1));
   assign ev_unf  = do_dec && (level == 5'h0_0);
   assign top_val = (level == 5'h0_0) ? '0 : stack[level];
   assign top_ext = 24'(top_val);
   assign O_TOP   = top_val;

   always_comb begin
      next_top_ext = top_ext;
      unique case (I_BUS.addr)
         ras_pkg::ADDR_TOP_LOW: next_top_ext[7:0] = I_BUS.wdata;
         ras_pkg::ADDR_TOP_HIGH: next_top_ext[15:8] = I_BUS.wdata;
         ras_pkg::ADDR_TOP_UPP: next_top_ext[23:16] = I_BUS.wdata;
         default: next_top_ext = top_ext;
      endcase
   end

   always_comb begin
      next_level = level;
      if (wr_ptr) begin
         next_level = I_BUS.wdata[ras_pkg::LEVEL_MSB:0];
      end else if (do_inc && level < 5'(DEPTH)) begin
         next_level = level + 5'h0_1;
      end else if (do_dec && level != 5'h0_0) begin
         next_level = level - 5'h0_1;
      end
   end

   // pointer
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         level <= ras_pkg::LEVEL_RST;
      end else begin
         level <= next_level;
      end
   end

   // stack storage, no reset needed
   always_ff @(posedge I_CLK) begin
      if (!wr_ptr && do_inc && level < 5'(DEPTH)) begin
         stack[level + 5'h0_1] <= I_PC;
      end else if (wr_top && level != 5'h0_0) begin
         stack[level] <= next_top_ext[PC_W-1:0];
      end
   end

   // flags: hardware set wins over a software clear, power-on reset only
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         full_flag <= 1'b0;
         unf_flag  <= 1'b0;
      end else begin
         if (ev_full) begin
            full_flag <= 1'b1;
         end else if (wr_ptr && !I_BUS.wdata[ras_pkg::FULL_BIT]) begin
            full_flag <= 1'b0;
         end
         if (ev_unf) begin
            unf_flag <= 1'b1;
         end else if (wr_ptr && !I_BUS.wdata[ras_pkg::UNF_BIT]) begin
            unf_flag <= 1'b0;
         end
      end
   end

   // configuration
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         ovr_rst_en <= ras_pkg::CONFIG_RST[0];
      end else if (I_BUS.wr && I_BUS.addr == ras_pkg::ADDR_CONFIG) begin
         ovr_rst_en <= I_BUS.wdata[0];
      end
   end

   // device reset request rises in the same cycle as the flag, one cycle after the event
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_DEV_RESET <= 1'b0;
      end else begin
         O_DEV_RESET <= ovr_rst_en && (ev_full || ev_unf);
      end
   end

   // interrupt status, enable
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         irq_stat <= '0;
         irq_en   <= '0;
      end else begin
         irq_stat <= (irq_stat & ~((I_BUS.wr && I_BUS.addr == ras_pkg::ADDR_IRQ_CLR) ?
                     I_BUS.wdata[ras_pkg::IRQ_W-1:0] : '0)) | {ev_unf, ev_full};
         if (I_BUS.wr && I_BUS.addr == ras_pkg::ADDR_IRQ_EN) begin
            irq_en <= I_BUS.wdata[ras_pkg::IRQ_W-1:0];
         end
      end
   end

   assign O_IRQ = |(irq_stat & irq_en);

   // read data one cycle after the strobe
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_RDATA <= 8'h0_0;
      end else if (I_BUS.rd) begin
         unique case (I_BUS.addr)
            ras_pkg::ADDR_STACK_PTR: O_RDATA <= {full_flag, unf_flag, 1'b0, level};
            ras_pkg::ADDR_TOP_LOW:  O_RDATA <= top_ext[7:0];
            ras_pkg::ADDR_TOP_HIGH: O_RDATA <= top_ext[15:8];
            ras_pkg::ADDR_TOP_UPP:  O_RDATA <= top_ext[23:16];
            ras_pkg::ADDR_CONFIG:   O_RDATA <= {7'h0_0, ovr_rst_en};
            ras_pkg::ADDR_IRQ_STAT: O_RDATA <= 8'(irq_stat);
            ras_pkg::ADDR_IRQ_CLR:  O_RDATA <= 8'h0_0;
            ras_pkg::ADDR_IRQ_EN:   O_RDATA <= 8'(irq_en);
         endcase
      end else begin
         O_RDATA <= 8'h0_0;
      end
   end

   // assertions
   push_moves_ptr_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (do_inc && !wr_ptr && level < 5'(DEPTH)) |=> level == $past(level) + 5'h0_1)
      else $error("push did not advance pointer");
   push_stores_pc_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (do_inc && !wr_ptr && level < 5'(DEPTH)) |=> O_TOP == $past(I_PC))
      else $error("push did not store pc");
   pop_moves_ptr_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (do_dec && !do_inc && !wr_ptr && level != 5'h0_0) |=> level == $past(level) - 5'h0_1)
      else $error("pop did not lower pointer");
   full_sets_flag_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      ev_full |=> full_flag)
      else $error("full flag not set");
   unf_sets_flag_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      ev_unf |=> unf_flag)
      else $error("underflow flag not set");
   reset_when_enabled_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      ((ev_full || ev_unf) && ovr_rst_en) |=> O_DEV_RESET && (full_flag || unf_flag))
      else $error("no device reset on stack fault");
   no_reset_disabled_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      O_DEV_RESET |-> $past(ovr_rst_en))
      else $error("device reset while disabled");
   flag_holds_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (full_flag && !wr_ptr) |=> full_flag)
      else $error("full flag lost without write");
   config_write_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (I_BUS.wr && I_BUS.addr == ras_pkg::ADDR_CONFIG) |=> ovr_rst_en == $past(I_BUS.wdata[0]))
      else $error("config bit not written");
   top_write_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (wr_top && I_BUS.addr == ras_pkg::ADDR_TOP_LOW && level != 5'h0_0 && !do_inc && !do_dec)
      |=> O_TOP[7:0] == $past(I_BUS.wdata))
      else $error("top low byte not written");
   ptr_read_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (I_BUS.rd && I_BUS.addr == ras_pkg::ADDR_STACK_PTR) |=> O_RDATA[5] == 1'b0 &&
      O_RDATA[4:0] == $past(level))
      else $error("pointer read wrong");
   read_top_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (I_BUS.rd && I_BUS.addr == ras_pkg::ADDR_TOP_LOW) |=> O_RDATA == $past(top_ext[7:0]))
      else $error("top read wrong");

   // pointer register writes, flag clears and flag holds
   level_write_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      wr_ptr |=> level == $past(I_BUS.wdata[ras_pkg::LEVEL_MSB:0]))
      else $error("pointer write not taken");

   full_clear_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (wr_ptr && !I_BUS.wdata[ras_pkg::FULL_BIT] && !ev_full) |=> !full_flag)
      else $error("full flag not cleared by write");

   unf_clear_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (wr_ptr && !I_BUS.wdata[ras_pkg::UNF_BIT] && !ev_unf) |=> !unf_flag)
      else $error("underflow flag not cleared by write");

   unf_holds_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (unf_flag && !wr_ptr) |=> unf_flag)
      else $error("underflow flag lost without write");

   full_keep_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (full_flag && wr_ptr && I_BUS.wdata[ras_pkg::FULL_BIT]) |=> full_flag)
      else $error("full flag lost on keep write");

   // edge cases of the pointer
   pop_at_zero_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (ev_unf && !wr_ptr && !do_inc) |=> level == 5'h0_0)
      else $error("pointer moved on underflow");

   full_no_move_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (do_inc && !wr_ptr && level == 5'(DEPTH)) |=> level == 5'(DEPTH))
      else $error("pointer moved past full");

   top_empty_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (level == 5'h0_0) |-> O_TOP == '0)
      else $error("top not zero when empty");

   // top entry byte writes
   top_high_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (wr_top && I_BUS.addr == ras_pkg::ADDR_TOP_HIGH && level != 5'h0_0 && !do_inc && !do_dec)
      |=> O_TOP[15:8] == $past(I_BUS.wdata))
      else $error("top high byte not written");

   top_upper_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (wr_top && I_BUS.addr == ras_pkg::ADDR_TOP_UPP && level != 5'h0_0 && !do_inc && !do_dec)
      |=> O_TOP[PC_W-1:16] == $past(I_BUS.wdata[PC_W-17:0]))
      else $error("top upper byte not written");

   // device reset request
   reset_cause_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      O_DEV_RESET |-> $past(ev_full || ev_unf))
      else $error("device reset without stack fault");

   reset_quiet_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      ((ev_full || ev_unf) && !ovr_rst_en) |=> !O_DEV_RESET)
      else $error("device reset with enable clear");

   // interrupt status
   irq_full_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      ev_full |=> irq_stat[ras_pkg::IRQ_FULL])
      else $error("full status not set");

   irq_unf_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      ev_unf |=> irq_stat[ras_pkg::IRQ_UNF])
      else $error("underflow status not set");

   // read port
   rdata_idle_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      !I_BUS.rd |=> O_RDATA == 8'h0_0)
      else $error("read data not idle");

   read_high_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (I_BUS.rd && I_BUS.addr == ras_pkg::ADDR_TOP_HIGH) |=> O_RDATA == $past(top_ext[15:8]))
      else $error("top high read wrong");

   read_upper_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (I_BUS.rd && I_BUS.addr == ras_pkg::ADDR_TOP_UPP) |=> O_RDATA == $past(top_ext[23:16]))
      else $error("top upper read wrong");

   // main scenarios
   push_c: cover property (@(posedge I_CLK) disable iff (!I_RSTN) I_OP.push ##1 wr_top);
   unf_c: cover property (@(posedge I_CLK) disable iff (!I_RSTN) ev_unf);
   pop_c: cover property (@(posedge I_CLK) disable iff (!I_RSTN) I_OP.pop && level != 5'h0_0);
   full_c: cover property (@(posedge I_CLK) disable iff (!I_RSTN) ev_full);
   reset_c: cover property (@(posedge I_CLK) disable iff (!I_RSTN) O_DEV_RESET);
endmodule

`default_nettype wire

// ==== testbench/ras_seq_model.sv ====
// sequencer model issuing push, pop, call and return pulses
`timescale 1ns/1ps
`default_nettype none
module ras_seq_model #(
   parameter int PC_W = 21
) (
   // clock
   input  wire logic             i_clk,
   // operations toward the stack
   output var ras_pkg::ras_op_t  o_op,
   output var logic [PC_W-1:0]   o_pc
);
   initial begin
      o_op = '0;
      o_pc = '0;
   end
   // one-cycle pulse; the pc turns over once no op qualifies it
   task automatic issue(input ras_pkg::ras_op_t op, input logic [PC_W-1:0] pc);
      @(posedge i_clk);
      o_op <= op;
      o_pc <= pc;
      @(posedge i_clk);
      o_op <= '0;
      o_pc <= ~pc;
   endtask
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// self-checking bench for the return-address stack block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam ras_pkg::ras_op_t PUSH = 4'b1000;
   localparam ras_pkg::ras_op_t POP  = 4'b0100;
   localparam ras_pkg::ras_op_t CALL = 4'b0010;
   localparam ras_pkg::ras_op_t RET  = 4'b0001;
   logic              clk;
   logic              rst_n;
   ras_pkg::ras_bus_t bus;
   ras_pkg::ras_op_t  op;
   logic [20:0]       pc;
   logic [20:0]       top;
   logic [7:0]        rdata;
   logic              dev_reset;
   logic              irq;
   int                bad_count;
   int                checked;

   ras_seq_model #(.PC_W(21)) SEQ (.i_clk(clk), .o_op(op), .o_pc(pc));
   ras_ctrl #(.PC_W(21), .DEPTH(31)) DUT (.I_CLK(clk), .I_RSTN(rst_n), .I_OP(op),
      .I_PC(pc), .O_TOP(top), .I_BUS(bus), .O_RDATA(rdata),
      .O_DEV_RESET(dev_reset), .O_IRQ(irq));

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus <= '0;
   endtask
   task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus <= '0;
      #1;
      chk({16'h0000, rdata}, {16'h0000, exp});
   endtask
   task automatic op_chk(input ras_pkg::ras_op_t o, input logic [20:0] p,
                         input logic [20:0] exp);
      SEQ.issue(o, p);
      #1;
      chk({3'h0, top}, {3'h0, exp});
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      #(50 * 3000);
      bad_count++;
      wrap_up();
   end
   initial begin
      bad_count = 0;
      checked = 0;
      bus = '0;
      rst_n = 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(ras_pkg::ADDR_STACK_PTR, 8'h00);
      rd_chk(ras_pkg::ADDR_CONFIG, 8'h00);
      wr_reg(ras_pkg::ADDR_STACK_PTR, 8'h25);
      rd_chk(ras_pkg::ADDR_STACK_PTR, 8'h05);
      @(posedge clk);
      #1;
      chk({16'h0000, rdata}, 24'h00_0000);
      wr_reg(ras_pkg::ADDR_STACK_PTR, 8'h00);
      op_chk(PUSH, 21'h1_2345, 21'h1_2345);
      rd_chk(ras_pkg::ADDR_STACK_PTR, 8'h01);
      wr_reg(ras_pkg::ADDR_TOP_LOW, 8'hab);
      wr_reg(ras_pkg::ADDR_TOP_HIGH, 8'hcd);
      wr_reg(ras_pkg::ADDR_TOP_UPP, 8'h1e);
      #1;
      chk({3'h0, top}, 24'h1E_CDAB);
      rd_chk(ras_pkg::ADDR_TOP_LOW, 8'hab);
      rd_chk(ras_pkg::ADDR_TOP_HIGH, 8'hcd);
      rd_chk(ras_pkg::ADDR_TOP_UPP, 8'h1e);
      op_chk(CALL, 21'h0_0777, 21'h0_0777);
      op_chk(RET, 21'h0_0000, 21'h1E_CDAB);
      op_chk(POP, 21'h0_0000, 21'h0_0000);
      rd_chk(ras_pkg::ADDR_STACK_PTR, 8'h00);
      op_chk(POP, 21'h0_0000, 21'h0_0000);
      chk({23'h00_0000, dev_reset}, 24'h00_0000);
      rd_chk(ras_pkg::ADDR_STACK_PTR, 8'h40);
      rd_chk(ras_pkg::ADDR_IRQ_STAT, 8'h02);
      chk({23'h00_0000, irq}, 24'h00_0000);
      wr_reg(ras_pkg::ADDR_IRQ_EN, 8'h03);
      #1;
      chk({23'h00_0000, irq}, 24'h00_0001);
      wr_reg(ras_pkg::ADDR_IRQ_CLR, 8'h02);
      #1;
      chk({23'h00_0000, irq}, 24'h00_0000);
      rd_chk(ras_pkg::ADDR_STACK_PTR, 8'h40);
      wr_reg(ras_pkg::ADDR_STACK_PTR, 8'h1e);
      rd_chk(ras_pkg::ADDR_STACK_PTR, 8'h1e);
      wr_reg(ras_pkg::ADDR_CONFIG, 8'h01);
      op_chk(PUSH, 21'h0_0abc, 21'h0_0abc);
      chk({23'h00_0000, dev_reset}, 24'h00_0001);
      chk({23'h00_0000, irq}, 24'h00_0001);
      @(posedge clk);
      #1;
      chk({23'h00_0000, dev_reset}, 24'h00_0000);
      rd_chk(ras_pkg::ADDR_STACK_PTR, 8'h9f);
      wr_reg(ras_pkg::ADDR_STACK_PTR, 8'h80);
      op_chk(POP, 21'h0_0000, 21'h0_0000);
      chk({23'h00_0000, dev_reset}, 24'h00_0001);
      rd_chk(ras_pkg::ADDR_STACK_PTR, 8'hc0);
      wr_reg(ras_pkg::ADDR_STACK_PTR, 8'h00);
      rd_chk(ras_pkg::ADDR_STACK_PTR, 8'h00);
      wrap_up();
   end
endmodule
`default_nettype wire
